// ### hw/ferx_dec5b.sv
`default_nettype none
module ferx_dec5b (
   // Aligned code-group
   input  wire logic [4:0] code_in,
   // Nibble and validity
   output logic [3:0]      nib_out,
   output logic            data_ok_out
);
   // Standard 4B/5B data table; control and void codes are not data
   always_comb
   begin
      data_ok_out = 1'b1;
      case (code_in)
         5'h1E:   nib_out = 4'h0;
         5'h09:   nib_out = 4'h1;
         5'h14:   nib_out = 4'h2;
         5'h15:   nib_out = 4'h3;
         5'h0A:   nib_out = 4'h4;
         5'h0B:   nib_out = 4'h5;
         5'h0E:   nib_out = 4'h6;
         5'h0F:   nib_out = 4'h7;
         5'h12:   nib_out = 4'h8;
         5'h13:   nib_out = 4'h9;
         5'h16:   nib_out = 4'hA;
         5'h17:   nib_out = 4'hB;
         5'h1A:   nib_out = 4'hC;
         5'h1B:   nib_out = 4'hD;
         5'h1C:   nib_out = 4'hE;
         5'h1D:   nib_out = 4'hF;
         default:
         begin
            nib_out     = 4'hE;
            data_ok_out = 1'b0;
         end
      endcase
   end
endmodule : ferx_dec5b
`default_nettype wire

// ### hw/ferx_fifo.sv
`default_nettype none
module ferx_fifo #(
   parameter int W = 5,
   parameter int D = 4
) (
   // Clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         reset_n_in,
   // Fill side
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   // Drain side
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out,
   // Fill level
   output logic [$clog2(D):0] level_out
);
   localparam int AW = $clog2(D);

   // Whole state of the queue
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
   } ferx_fifo_s;

   ferx_fifo_s q, d;
   logic       push;
   logic       pop;

   assign in_ready_out  = (q.cnt != (AW+1)'(D));
   assign out_valid_out = (q.cnt != '0);
   assign out_data_out  = q.mem[q.rd];
   assign level_out     = q.cnt;
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // Pointer and count update
   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wr] = in_data_in;
         d.wr        = q.wr + 1'b1;
      end
      if (pop)
      begin
         d.rd = q.rd + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         q <= '0;
      else
         q <= d;
   end
endmodule : ferx_fifo
`default_nettype wire

// ### hw/ferx_pcs_rx.sv
`default_nettype none
// Operation
// RL1 - Link pulses never raise signal detect
// RL2 - Group received bits into 5-bit symbols
// RL3 - Descramble by XOR with regenerated key
// RL4 - Lock after twelve idle groups
// RL5 - 722 us hold, restarted by 58 idle bits
// RL6 - Hold expiry drops lock, resets descrambler
// RL7 - Align symbols on the J/K pair
// RL8 - J/K becomes two 0101 preamble nibbles
// RL9 - Decode until T/R or two idles
// RL10 - Link up after 395 us signal detect
// RL11 - Idle to non-idle without J/K is bad
// RL12 - Bad start sends error, 1110 per group
// RL13 - Bad start bumps false carrier counter
// RL14 - Two idles end error and carrier
// RL15 - Control groups in data are errors
// RL16 - Non-data groups flagged as errors
// RL17 - MAC discards frames carrying errors
module ferx_pcs_rx #(
   parameter int LINK_CYCLES = ferx_pkg::LINK_CYC,
   parameter int HOLD_CYCLES = ferx_pkg::HOLD_CYC
) (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        reset_n_in,
   // Raw energy detect from the analog front end (asynchronous pin)
   input  wire logic        sig_raw_in,
   // Recovered NRZ bit stream, same clock
   input  wire logic        rx_bit_valid_in,
   input  wire logic        rx_bit_in,
   output logic             rx_bit_ready_out,
   input  wire logic        descr_bypass_in,
   // MII receive side
   output logic             rx_dv_out,
   output logic             rx_er_out,
   output logic [3:0]       rxd_out,
   input  wire logic        mii_ready_in,
   output logic             crs_out,
   // Status
   output logic             sig_det_out,
   output logic             link_up_out,
   output logic             lock_out,
   output logic [15:0]      false_carrier_event_counter_out
);
   // Whole block state
   typedef struct packed {
      logic [2:0]          sync;      // Pin synchroniser, [0] first stage
      logic                sd_filt;   // Agreed pin level
      logic [5:0]          sd_cnt;    // Qualify counter
      logic                sig_det;
      logic [14:0]         link_cnt;
      logic                link_up;
      logic [10:0]         lfsr;      // Key generator
      logic                lock;
      logic [5:0]          run;       // Matching idle bits while hunting
      logic [15:0]         hold;      // Hold countdown
      logic [5:0]          ones;      // Consecutive descrambled ones
      logic [9:0]          win;       // Last ten data bits
      ferx_pkg::ferx_st_e  st;
      logic [2:0]          bcnt;      // Bit phase inside a group
      logic                t_seen;
      logic                idle_g;    // Previous group was idle
      logic                crs;
      logic [15:0]         fcc;
      logic                wr_v;
      logic [4:0]          wr_d;      // {error, nibble}
      logic                pre_pend;  // Second preamble nibble owed
      logic                bit_rdy;
      logic                dv;
      logic                er;
      logic [3:0]          rxd;
   } ferx_s;

   ferx_s      q, d;
   logic       key;
   logic       sd;
   logic       ud;
   logic       go;
   logic       data_ok;
   logic [9:0] win_n;
   logic [4:0] grp;
   logic [3:0] dec_nib;
   logic       dec_ok;
   logic       fifo_ready;
   logic       fifo_ov;
   logic [4:0] fifo_od;
   logic [2:0] fifo_lvl;
   logic       take;

   // Group lookup
   ferx_dec5b u_dec (
      .code_in     (grp),
      .nib_out     (dec_nib),
      .data_ok_out (dec_ok)
   );

   // Nibble queue toward the MII
   ferx_fifo #(
      .W (ferx_pkg::FIFO_W),
      .D (ferx_pkg::FIFO_D)
   ) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (q.wr_v),
      .in_ready_out  (fifo_ready),
      .in_data_in    (q.wr_d),
      .out_valid_out (fifo_ov),
      .out_ready_in  (take),
      .out_data_out  (fifo_od),
      .level_out     (fifo_lvl)
   );

   // Stream helpers
   assign sd      = rx_bit_in;
   assign go      = rx_bit_valid_in && q.bit_rdy && q.link_up;
   // RL3 - key tap XOR
   assign key     = q.lfsr[10] ^ q.lfsr[8];
   assign ud      = descr_bypass_in ? sd : (sd ^ key);
   assign data_ok = descr_bypass_in || q.lock;
   assign win_n   = {q.win[8:0], ud};
   assign grp     = win_n[4:0];
   assign take    = fifo_ov && (!q.dv || mii_ready_in);

   // Next-state logic
   always_comb
   begin
      d         = q;
      d.wr_v    = 1'b0;
      d.sync    = {q.sync[1:0], sig_raw_in};
      // Pin level changes once second and third stages agree
      if (q.sync[1] == q.sync[2])
         d.sd_filt = q.sync[2];
      // RL1 - pulses shorter than qualify time ignored
      if (!q.sd_filt)
      begin
         d.sd_cnt  = '0;
         d.sig_det = 1'b0;
      end
      else if (q.sd_cnt == 6'(ferx_pkg::SD_QUAL_CYC - 1))
         d.sig_det = 1'b1;
      else
         d.sd_cnt = q.sd_cnt + 6'h01;
      // RL10 - continuous detect before link-up
      if (!q.sig_det)
      begin
         d.link_cnt = '0;
         d.link_up  = 1'b0;
      end
      else if (q.link_cnt == 15'(LINK_CYCLES - 1))
         d.link_up = 1'b1;
      else
         d.link_cnt = q.link_cnt + 15'h0001;
      // Room for the pushes that may already be in flight
      d.bit_rdy = (fifo_lvl < 3'(ferx_pkg::FIFO_D - 2));
      // RL8 - second preamble nibble
      if (q.pre_pend)
      begin
         d.wr_v     = 1'b1;
         d.wr_d     = {1'b0, ferx_pkg::NIB_PRE};
         d.pre_pend = 1'b0;
      end
      // RL5 - hold countdown runs while locked
      if (q.lock && !descr_bypass_in)
         d.hold = q.hold - 16'h0001;
      if (go && !descr_bypass_in && !q.lock)
      begin
         // RL4 - hunt: seed with inverted bits, count predicted idles
         d.lfsr = {q.lfsr[9:0], ~sd};
         d.run  = (key == ~sd) ? q.run + 6'h01 : 6'h00;
         if ((key == ~sd) && (q.run == 6'(ferx_pkg::LOCK_BITS - 1)))
         begin
            d.lock = 1'b1;
            d.hold = 16'(HOLD_CYCLES);
         end
      end
      else if (go && !descr_bypass_in)
      begin
         // RL3 - free-running key once locked
         d.lfsr = {q.lfsr[9:0], key};
         // RL5 - enough idle restarts the countdown
         // Kept fresh through long idle runs, as the ones count saturates
         if (ud && (q.ones >= 6'(ferx_pkg::HOLD_IDLE_BITS - 1)))
            d.hold = 16'(HOLD_CYCLES);
      end
      // RL6 - expiry forces a full reacquire
      if (q.lock && !descr_bypass_in && (q.hold == 16'h0000))
      begin
         d.lock = 1'b0;
         d.lfsr = ferx_pkg::LFSR_RST;
         d.run  = '0;
      end
      if (!data_ok || !q.link_up)
      begin
         // Lost lock or link aborts any frame in progress
         d.st     = ferx_pkg::ST_IDLE;
         d.crs    = 1'b0;
         d.t_seen = 1'b0;
         d.ones   = '0;
      end
      else if (go)
      begin
         // RL2 - bits gathered into five-bit groups
         d.win  = win_n;
         d.ones = (ud && (q.ones != 6'h3F)) ? q.ones + 6'h01 : (ud ? q.ones : 6'h00);
         case (q.st)
            ferx_pkg::ST_IDLE:
            begin
               // First zero after two idles opens a start check
               if (!ud && (q.ones >= 6'(ferx_pkg::PRE_IDLE_BITS)))
               begin
                  d.st   = ferx_pkg::ST_CAND;
                  d.bcnt = '0;
               end
            end
            ferx_pkg::ST_CAND:
            begin
               d.bcnt = q.bcnt + 3'h1;
               if (q.bcnt == 3'(ferx_pkg::JK_TAIL_BITS - 1))
               begin
                  d.bcnt   = '0;
                  d.crs    = 1'b1;
                  d.idle_g = 1'b0;
                  d.t_seen = 1'b0;
                  // RL7 - group boundary fixed on J/K
                  if (win_n == ferx_pkg::SYM_JK)
                  begin
                     // RL8 - first preamble nibble
                     d.st       = ferx_pkg::ST_PKT;
                     d.wr_v     = 1'b1;
                     d.wr_d     = {1'b0, ferx_pkg::NIB_PRE};
                     d.pre_pend = 1'b1;
                  end
                  else
                  begin
                     // RL11 - no J/K in front of activity
                     d.st  = ferx_pkg::ST_BAD;
                     // RL13 - false carrier count
                     d.fcc = q.fcc + 16'h0001;
                  end
               end
            end
            default:
            begin
               d.bcnt = q.bcnt + 3'h1;
               if (q.bcnt == 3'(ferx_pkg::GRP_W - 1))
               begin
                  d.bcnt   = '0;
                  d.idle_g = (grp == ferx_pkg::SYM_I);
                  // RL9 - two idles or T/R close the frame
                  // RL14 - two idles also drop carrier after a bad start
                  if ((grp == ferx_pkg::SYM_I) && q.idle_g)
                  begin
                     d.st  = ferx_pkg::ST_IDLE;
                     d.crs = 1'b0;
                  end
                  else if (q.st == ferx_pkg::ST_BAD)
                  begin
                     // RL12 - error nibble for each group
                     d.wr_v = 1'b1;
                     d.wr_d = {1'b1, ferx_pkg::NIB_BAD};
                  end
                  else if (q.t_seen && (grp == ferx_pkg::SYM_R))
                  begin
                     d.st  = ferx_pkg::ST_IDLE;
                     d.crs = 1'b0;
                  end
                  else if ((grp == ferx_pkg::SYM_T) && !q.t_seen)
                     d.t_seen = 1'b1;
                  else
                  begin
                     // RL15 - control groups in data give errors
                     // RL16 - lookup miss flagged to the MAC
                     d.t_seen = 1'b0;
                     d.wr_v   = 1'b1;
                     d.wr_d   = {!dec_ok || q.t_seen, dec_nib};
                  end
               end
            end
         endcase
      end
      // Output stage; RL17 leaves error frames to the MAC
      if (take)
      begin
         d.dv  = 1'b1;
         d.er  = fifo_od[4];
         d.rxd = fifo_od[3:0];
      end
      else if (mii_ready_in)
      begin
         // RL14 - error falls with valid, never lingers after idles
         d.dv = 1'b0;
         d.er = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         q <= '0;
      else
         q <= d;
   end

   // Outputs straight from flops
   assign rx_bit_ready_out                = q.bit_rdy;
   assign rx_dv_out                       = q.dv;
   assign rx_er_out                       = q.er;
   assign rxd_out                         = q.rxd;
   assign crs_out                         = q.crs;
   assign sig_det_out                     = q.sig_det;
   assign link_up_out                     = q.link_up;
   assign lock_out                        = q.lock;
   assign false_carrier_event_counter_out = q.fcc;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);

   a_sd_qualify: assert property ($rose(q.sig_det) |-> $past(q.sd_cnt, 1) == 6'(ferx_pkg::SD_QUAL_CYC - 1) && $past(q.sd_filt)) else $error("signal detect without qualify"); // RL1
   a_lock_idles: assert property ($rose(q.lock) |-> $past(q.run, 1) == 6'(ferx_pkg::LOCK_BITS - 1)) else $error("lock before twelve idles"); // RL4
   a_hold_load: assert property ($rose(q.lock) |-> q.hold == 16'(HOLD_CYCLES)) else $error("hold not loaded"); // RL5
   a_hold_drop: assert property (q.lock && !descr_bypass_in && q.hold == 16'h0000 |=> !q.lock && q.lfsr == ferx_pkg::LFSR_RST) else $error("hold expiry kept lock"); // RL6
   a_link_wait: assert property ($rose(q.link_up) |-> $past(q.link_cnt, 1) == 15'(LINK_CYCLES - 1)) else $error("link up too early"); // RL10
   a_pre_pair: assert property (q.st != ferx_pkg::ST_PKT ##1 q.st == ferx_pkg::ST_PKT |-> q.wr_v && q.wr_d == 5'h05 ##1 q.wr_v && q.wr_d == 5'h05) else $error("preamble pair wrong"); // RL8
   a_bad_count: assert property (q.st != ferx_pkg::ST_BAD ##1 q.st == ferx_pkg::ST_BAD |-> q.fcc == $past(q.fcc) + 16'h0001 && q.crs) else $error("false carrier not counted"); // RL13
   a_bad_nibble: assert property (q.wr_v && q.st == ferx_pkg::ST_BAD |-> q.wr_d == {1'b1, ferx_pkg::NIB_BAD}) else $error("bad start nibble wrong"); // RL12
   a_crs_clear: assert property (q.st == ferx_pkg::ST_BAD ##1 q.st == ferx_pkg::ST_IDLE |-> !q.crs) else $error("carrier stuck after idles"); // RL14

   c_lock: cover property ($rose(q.lock));
   c_frame: cover property (q.st == ferx_pkg::ST_PKT ##[1:1000] q.st == ferx_pkg::ST_IDLE);
   c_false: cover property ($rose(q.st == ferx_pkg::ST_BAD));
   c_full: cover property (!fifo_ready);
endmodule : ferx_pcs_rx
`default_nettype wire

// ### hw/ferx_pkg.sv
`default_nettype none
package ferx_pkg;
   // Timing base
   localparam int CLK_MHZ        = 50;
   localparam int SD_QUAL_NS     = 1000;   // Qualify time, longer than any link pulse
   localparam int SD_QUAL_CYC    = (SD_QUAL_NS * CLK_MHZ + 999) / 1000;
   localparam int LINK_US        = 395;    // Signal detect hold before link-up
   localparam int LINK_CYC       = LINK_US * CLK_MHZ;
   localparam int HOLD_US        = 722;    // Descrambler hold countdown
   localparam int HOLD_CYC       = HOLD_US * CLK_MHZ;
   // Stream figures
   localparam int LOCK_IDLE_GRPS = 12;
   localparam int GRP_W          = 5;
   localparam int LOCK_BITS      = LOCK_IDLE_GRPS * GRP_W;
   localparam int HOLD_IDLE_BITS = 58;
   localparam int PRE_IDLE_BITS  = 10;     // Two idle groups ahead of a start
   localparam int JK_TAIL_BITS   = 7;      // Bits of J/K after its first zero
   // Code-groups
   localparam logic [4:0] SYM_I  = 5'h1F;
   localparam logic [4:0] SYM_T  = 5'h0D;
   localparam logic [4:0] SYM_R  = 5'h07;
   localparam logic [9:0] SYM_JK = 10'h311;
   // Nibbles and widths
   localparam logic [3:0] NIB_PRE  = 4'h5;
   localparam logic [3:0] NIB_BAD  = 4'hE;
   localparam logic [10:0] LFSR_RST = 11'h000;
   localparam int FIFO_W = 5;
   localparam int FIFO_D = 4;
   // Receive framing states, Gray along idle, candidate, packet
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CAND = 2'h1,
      ST_PKT  = 2'h3,
      ST_BAD  = 2'h2
   } ferx_st_e;
endpackage : ferx_pkg
`default_nettype wire

// ### sim/ferx_mac_model.sv
`default_nettype none
module ferx_mac_model (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        reset_n_in,
   // MII receive side
   input  wire logic        rx_dv_in,
   input  wire logic        rx_er_in,
   input  wire logic [3:0]  rxd_in,
   input  wire logic        crs_in,
   output logic             mii_ready_out,
   // Bench control and observation
   input  wire logic        stall_in,
   output logic             got_out,
   output logic             got_er_out,
   output logic [3:0]       got_nib_out,
   output logic [15:0]      dropped_out
);
   logic frame_bad_q;   // Error seen in the current frame

   // Back-pressure only where the bench asks for it
   assign mii_ready_out = reset_n_in & ~stall_in;

   // Capture accepted nibbles, one-cycle pulse for the bench
   // discard frames with errors
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
      if (!reset_n_in)
      begin
         got_out     <= 1'b0;
         got_er_out  <= 1'b0;
         got_nib_out <= 4'h0;
         frame_bad_q <= 1'b0;
         dropped_out <= 16'h0;
      end
      else
      begin
         got_out     <= rx_dv_in & mii_ready_out;
         got_er_out  <= rx_er_in;
         got_nib_out <= rxd_in;
         // Corrupt nibble marks the frame; carrier end discards it
         if (rx_dv_in && mii_ready_out && rx_er_in)
            frame_bad_q <= 1'b1;
         else if (!crs_in && frame_bad_q)
         begin
            frame_bad_q <= 1'b0;
            dropped_out <= dropped_out + 16'h1;
         end
      end
endmodule : ferx_mac_model
`default_nettype wire

// ### sim/test_fast_ethernet_rx_pcs_decode.sv
`default_nettype none
module test_fast_ethernet_rx_pcs_decode;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LINK = 40;    // Shortened link-up wait
   localparam int HOLD = 400;   // Shortened hold countdown
   localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
      5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
   localparam logic [4:0] CTL [4] = '{5'h04, 5'h00, 5'h08, 5'h1F};   // H, two V, lone I
   // Stimulus
   logic        clk_sys_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        sig_raw_in = 1'b0;
   logic        bit_vld    = 1'b0;
   logic        bit_val    = 1'b0;
   logic        bypass     = 1'b1;
   logic        stall      = 1'b0;
   // Observed
   logic        bit_rdy, rx_dv, rx_er, crs, sig_det, link_up, lock, mii_rdy;
   logic        got, got_er;
   logic [3:0]  rxd, got_nib;
   logic [15:0] fc_cnt, dropped, c;
   // Bench model
   logic [4:0]  expq[$];
   logic [10:0] key_s = 11'h5A5;    // Far scrambler state, any non-zero value
   logic [16:0] rnd   = 17'h106E5;
   bit          scr   = 1'b0;
   bit          bad_mode = 1'b0;
   int          bad_seen = 0;
   int          n;
   int          miscompares = 0;
   int          comparisons = 0;

   always #10 clk_sys_in = ~clk_sys_in;

   ferx_pcs_rx #(.LINK_CYCLES(LINK), .HOLD_CYCLES(HOLD)) ferx_pcs_rx_i (
      .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .sig_raw_in(sig_raw_in),
      .rx_bit_valid_in(bit_vld), .rx_bit_in(bit_val), .rx_bit_ready_out(bit_rdy),
      .descr_bypass_in(bypass), .rx_dv_out(rx_dv), .rx_er_out(rx_er), .rxd_out(rxd),
      .mii_ready_in(mii_rdy), .crs_out(crs), .sig_det_out(sig_det),
      .link_up_out(link_up), .lock_out(lock), .false_carrier_event_counter_out(fc_cnt));

   ferx_mac_model ferx_mac_model_i (
      .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .rx_dv_in(rx_dv),
      .rx_er_in(rx_er), .rxd_in(rxd), .crs_in(crs), .mii_ready_out(mii_rdy),
      .stall_in(stall), .got_out(got), .got_er_out(got_er), .got_nib_out(got_nib),
      .dropped_out(dropped));

   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr_next

   task automatic check_nib(input logic [4:0] act, input logic [4:0] exp);
      comparisons++;
      if (act !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: nibble %h expected %h", $time, act, exp);
      end
   endtask : check_nib

   task automatic check_val(input logic [15:0] act, input logic [15:0] exp, input string s);
      comparisons++;
      if (act !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: %s is %h expected %h", $time, s, act, exp);
      end
   endtask : check_val

   // Random back-pressure from the MAC side
   always @(negedge clk_sys_in)
   begin
      rnd   <= lfsr_next(rnd);
      stall <= rnd[0] & rnd[2];
   end

   // Every accepted nibble against the model queue, or against the error nibble while bad_mode is set
   always @(negedge clk_sys_in)
      if (got === 1'b1)
      begin
         if (bad_mode)
         begin
            bad_seen++;
            check_nib({got_er, got_nib}, {1'b1, ferx_pkg::NIB_BAD});
         end
         else if (expq.size() == 0)
            check_val(16'h1, 16'h0, "extra nibble");
         else
            check_nib({got_er, got_nib}, expq.pop_front());
      end

   // One bit, held until the design takes it; scrambled when asked
   task automatic send_bit(input logic b);
      logic k;
      int   w;
      k = key_s[10] ^ key_s[8];
      if (scr)
      begin
         key_s = {key_s[9:0], k};
         b = b ^ k;
      end
      @(negedge clk_sys_in);
      bit_vld = 1'b1;
      bit_val = b;
      w = 0;
      while (!(bit_rdy === 1'b1 && link_up === 1'b1) && w < 500)
      begin
         @(negedge clk_sys_in);
         w++;
      end
      if (w >= 500)
         check_val(16'h0, 16'h1, "bit refused");
      @(posedge clk_sys_in);
   endtask : send_bit

   // Group sent first bit first
   task automatic send_grp(input logic [4:0] g);
      for (int i = 4; i >= 0; i--)
         send_bit(g[i]);
   endtask : send_grp

   task automatic idles(input int k);
      repeat (k) send_grp(ferx_pkg::SYM_I);
   endtask : idles

   task automatic bits_off;
      @(negedge clk_sys_in);
      bit_vld = 1'b0;
   endtask : bits_off

   task automatic drain;
      bits_off;
      repeat (60) @(negedge clk_sys_in);
      check_val(16'(expq.size()), 16'h0, "missing nibbles");
   endtask : drain

   // Frame: idles, J/K, data, optional bad group, T/R or idle end
   task automatic frame(input int k, input bit tr, input logic [5:0] ins);
      logic [3:0] d;
      idles(3);
      expq.push_back({1'b0, ferx_pkg::NIB_PRE});
      expq.push_back({1'b0, ferx_pkg::NIB_PRE});
      send_grp(ferx_pkg::SYM_JK[9:5]);
      send_grp(ferx_pkg::SYM_JK[4:0]);
      for (int i = 0; i < k; i++)
      begin
         d = rnd[7:4];
         expq.push_back({1'b0, d});
         send_grp(ENC[d]);
         if (i == 1 && ins[5])
         begin
            expq.push_back({1'b1, ferx_pkg::NIB_BAD});
            send_grp(ins[4:0]);
         end
      end
      if (tr)
      begin
         send_grp(ferx_pkg::SYM_T);
         send_grp(ferx_pkg::SYM_R);
      end
      else
         expq.push_back({1'b1, ferx_pkg::NIB_BAD});   // First closing idle is a lone idle
      idles(3);
      drain;
   endtask : frame

   // Second reset in mid-run, then wait for link again
   task automatic restart;
      int w;
      @(negedge clk_sys_in);
      reset_n_in = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      w = 0;
      while (link_up !== 1'b1 && w < 300)
      begin
         @(negedge clk_sys_in);
         w++;
      end
      check_val(16'(link_up), 16'h1, "link after restart");
   endtask : restart

   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   // Main sequence
   initial
   begin
      repeat (16) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      // Short pulse like a link pulse
      sig_raw_in = 1'b1;
      repeat (5) @(negedge clk_sys_in);
      sig_raw_in = 1'b0;
      repeat (100) @(negedge clk_sys_in);
      check_val(16'(sig_det), 16'h0, "detect on pulse");
      sig_raw_in = 1'b1;
      n = 0;
      while (sig_det !== 1'b1 && n < 200)
      begin
         @(negedge clk_sys_in);
         n++;
      end
      n = 0;
      while (link_up !== 1'b1 && n < 200)
      begin
         @(negedge clk_sys_in);
         n++;
      end
      check_val(16'(n >= LINK - 1 && n <= LINK + 1), 16'h1, "link delay");
      frame(6, 1'b1, 6'h00);
      frame(5, 1'b0, 6'h00);
      foreach (CTL[i])
         frame(4, 1'b1, {1'b1, CTL[i]});
      check_val(16'(dropped != 16'h0), 16'h1, "frames dropped");
      // Non-idle without J/K
      c = fc_cnt;
      bad_mode = 1'b1;
      bad_seen = 0;
      idles(3);
      send_grp(5'h04);
      send_grp(5'h15);
      send_grp(5'h0A);
      bits_off;
      check_val(16'(crs), 16'h1, "carrier on bad start");
      idles(3);
      drain;
      check_val(fc_cnt, c + 16'h1, "false carrier count");
      check_val(16'(bad_seen > 0), 16'h1, "error nibbles");
      check_val({14'h0, crs, rx_er}, 16'h0, "carrier after idles");
      bad_mode = 1'b0;
      // Scrambled stream from a fresh state
      restart;
      bypass = 1'b0;
      scr = 1'b1;
      idles(8);
      bits_off;
      check_val(16'(lock), 16'h0, "early lock");
      idles(8);
      drain;
      check_val(16'(lock), 16'h1, "lock");
      frame(6, 1'b1, 6'h00);
      idles(100);
      bits_off;
      check_val(16'(lock), 16'h1, "hold restart");
      bad_mode = 1'b1;
      repeat (500) send_bit(1'b0);
      bits_off;
      check_val(16'(lock), 16'h0, "hold expiry");
      idles(20);
      drain;
      check_val(16'(lock), 16'h1, "relock");
      final_report;
   end

   // Watchdog well beyond the expected run
   initial
   begin
      #(40000 * 20);
      miscompares++;
      final_report;
   end
endmodule : test_fast_ethernet_rx_pcs_decode
`default_nettype wire
